// ---- rtl/ssfd_pkg.sv ----
// constants and carriers of the superscalar fetch / dispatch / branch front end
// assumes one core clock, active-low asynchronous reset, pre-decoded fetch words
package ssfd_pkg;

  localparam int          IQ_DEPTH     = 6;
  localparam int          CB_DEPTH     = 5;
  localparam logic [2:0]  IQ_CNT_MAX   = 3'h6;
  localparam logic [2:0]  CB_CNT_MAX   = 3'h5;
  localparam logic [1:0]  FETCH_MAX    = 2'h2;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0100;
  localparam logic [31:0] INSN_BYTES   = 32'h0000_0004;
  localparam logic [31:0] CLEAR_WORD   = 32'h0000_0000;

  // execution unit codes
  localparam logic [2:0]  U_INT        = 3'h0;
  localparam logic [2:0]  U_FLT        = 3'h1;
  localparam logic [2:0]  U_LSU        = 3'h2;
  localparam logic [2:0]  U_SYS        = 3'h3;
  localparam logic [2:0]  U_BR         = 3'h4;

  // branch target kinds
  localparam logic [1:0]  BK_REL       = 2'h0;
  localparam logic [1:0]  BK_RET       = 2'h1;
  localparam logic [1:0]  BK_CNT       = 2'h2;

  // transfers with return-address / loop-count registers
  localparam logic [1:0]  XF_NONE      = 2'h0;
  localparam logic [1:0]  XF_TO_RET    = 2'h1;
  localparam logic [1:0]  XF_TO_CNT    = 2'h2;
  localparam logic [1:0]  XF_FROM      = 2'h3;

  typedef enum logic [1:0] {
    BS_IDLE = 2'b01,
    BS_SPEC = 2'b10
  } ssfd_bstate_e;

  typedef struct packed {
    logic [2:0]  unit;
    logic [1:0]  bk;
    logic        cond;
    logic        pred;
    logic        link;
    logic [4:0]  cbit;
    logic        sense;
    logic        wcond;
    logic        wr;
    logic [4:0]  dst;
    logic [4:0]  sa;
    logic [4:0]  sb;
    logic        fp;
    logic        ser;
    logic [1:0]  xfer;
    logic [15:0] disp;
  } ssfd_insn_s;

  typedef struct packed {
    ssfd_insn_s  i;
    logic [31:0] pc;
  } ssfd_iq_s;

  typedef struct packed {
    logic        v;
    logic        done;
    logic        spec;
    logic        wr;
    logic        fp;
    logic        wcond;
    logic [1:0]  xfer;
    logic [4:0]  dst;
    logic [31:0] data;
  } ssfd_cb_s;

  typedef struct packed {
    ssfd_insn_s  i;
    logic [2:0]  tag;
    logic        spec;
    logic [31:0] opa;
    logic [31:0] opb;
  } ssfd_disp_s;

  typedef struct packed {
    logic        v;
    logic [2:0]  tag;
    logic [31:0] data;
  } ssfd_done_s;

endpackage

// ---- rtl/ssfd_regfile.sv ----
// thirty-two word register file, two write ports, four read ports
// assumes writes come from in-order retirement; port 1 wins on same index
`timescale 1ns/1ns
module ssfd_regfile
  import ssfd_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [1:0]       we,
  input  wire logic [1:0][4:0]  waddr,
  input  wire logic [1:0][31:0] wdata,
  input  wire logic [3:0][4:0]  raddr,
  output logic      [3:0][31:0] rdata
);

  logic [31:0] regs_q [32];

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_reg
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          regs_q[g] <= CLEAR_WORD;
        end else if (we[1] && waddr[1] == 5'(g)) begin
          regs_q[g] <= wdata[1];
        end else if (we[0] && waddr[0] == 5'(g)) begin
          regs_q[g] <= wdata[0];
        end
      end
    end
    for (g = 0; g < 4; g++) begin : g_rd
      assign rdata[g] = regs_q[raddr[g]];
    end
  endgenerate

endmodule

// ---- rtl/ssfd_core.sv ----
// front-end control: fetch, six-entry queue, dual dispatch, branch folding,
// speculation, five-entry completion buffer and in-order retirement
// assumes cache answers the standing request in the same cycle; units same clock
// Contract
// - queue holds six entries, takes up to two fetched words per cycle
// - fetch requests every cycle as many words as the queue can take
// - at most two instructions dispatched per cycle
// - register dependencies and serialization hold back dispatch
// - unresolved conditional branch direction comes from its prediction bit
// - fetch follows the predicted stream until the condition is known
// - condition bits are watched so branches resolve early
// - resolvable branches are folded out without a dispatch slot
// - branches behind an unresolved prediction wait, never issued
// - speculative work runs but retires only after correct resolution
// - mispredict discards predicted path and restarts on the right one
// - call branches write next address into return-address register
// - branch-to-return uses return-address register as target
// - branch-to-counter uses loop-count register as target
// - both branch registers move to and from general registers
// - up to two issued and retired per clock, five in flight
// - integer unit takes one instruction at a time
// - integer results sit in rename entries, copied to general registers on retire
// - float results sit in rename entries, copied to float registers on retire
// - float pipe accepts a float instruction every cycle back to back
// - thirty-two general and thirty-two float registers
// - all float operand classes handled in the unit, no software trap
// - each dispatch takes a completion entry; dispatch stalls when none free
// - up to two retire per cycle in order from the buffer head
`timescale 1ns/1ns
module ssfd_core
  import ssfd_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           reset_n,
  output logic [31:0]         fetch_addr_q,
  output logic [1:0]          fetch_want_q,
  input  wire logic           fetch_ack,
  input  wire logic [1:0]     fetch_cnt,
  input  wire ssfd_insn_s [1:0] fetch_insn,
  input  wire logic [3:0]     rs_ready,
  input  wire logic           int_busy,
  output logic [1:0]          disp_valid_q,
  output ssfd_disp_s [1:0]    disp_q,
  input  wire ssfd_done_s [1:0] done_in,
  output logic                flush_q,
  output logic [1:0]          retire_cnt_q,
  output logic [31:0]         cond_reg_q,
  output logic [31:0]         return_q,
  output logic [31:0]         count_q
);

  function automatic logic [2:0] wrap5(input logic [3:0] x);
    return (x >= 4'(CB_DEPTH)) ? 3'(x - 4'(CB_DEPTH)) : x[2:0];
  endfunction

  function automatic logic chit(input logic wc, input logic [4:0] d, input logic [4:0] cb);
    return wc && d[2:0] == cb[4:2];
  endfunction

  function automatic logic dep(input ssfd_insn_s a, input logic wr, input logic fp,
                               input logic [4:0] d);
    return wr && fp == a.fp && (d == a.sa || d == a.sb || (a.wr && d == a.dst));
  endfunction

  ssfd_iq_s      iq_q [IQ_DEPTH];
  ssfd_iq_s      iq_d [IQ_DEPTH];
  logic [2:0]    iq_n_q, iq_n_d;
  ssfd_cb_s      cb_q [CB_DEPTH];
  logic [2:0]    cb_head_q, cb_n_q;
  ssfd_bstate_e  bs_q;
  logic [4:0]    pb_cbit_q;
  logic          pb_sense_q, pb_pred_q, pb_link_q;
  logic [31:0]   pb_alt_q, pb_ret_q;

  logic          pend_w, res_go, res_ok, flush;
  logic [1:0]    dgo, nd, nret, acc;
  logic [2:0]    nspec, free;
  logic          stop, hz, to_ret_fl, to_cnt_fl, cw;
  ssfd_iq_s      be;
  logic          bvalid, known, taken, tgt_busy, fold_go, fold_spec, redirect;
  logic [31:0]   br_tgt, redirect_pc;
  logic [1:0]    rgo;
  logic [2:0]    ridx [2];
  logic [3:0][4:0]  g_ra;
  logic [3:0][31:0] g_rd, f_rd;
  logic [1:0]       g_we, f_we;
  logic [1:0][4:0]  w_a;
  logic [1:0][31:0] w_d;

  // pending-branch watch on older condition writers
  always_comb begin
    pend_w = 1'b0;
    nspec  = 3'h0;
    for (int k = 0; k < CB_DEPTH; k++) begin
      if (cb_q[k].v && !cb_q[k].spec && chit(cb_q[k].wcond, cb_q[k].dst, pb_cbit_q)) begin
        pend_w = 1'b1;
      end
      if (cb_q[k].v && cb_q[k].spec) begin
        nspec = nspec + 3'h1;
      end
    end
    res_go = bs_q == BS_SPEC && !pend_w;
    res_ok = res_go && ((cond_reg_q[pb_cbit_q] == pb_sense_q) == pb_pred_q);
    flush  = res_go && !res_ok;
  end

  // dispatch of up to two from the queue head
  always_comb begin
    dgo       = 2'b00;
    stop      = flush;
    free      = CB_CNT_MAX - cb_n_q;
    to_ret_fl = 1'b0;
    to_cnt_fl = 1'b0;
    hz        = 1'b0;
    for (int k = 0; k < CB_DEPTH; k++) begin
      if (cb_q[k].v) begin
        to_ret_fl = to_ret_fl || cb_q[k].xfer == XF_TO_RET;
        to_cnt_fl = to_cnt_fl || cb_q[k].xfer == XF_TO_CNT;
      end
    end
    for (int i = 0; i < 2; i++) begin
      hz = 1'b0;
      for (int k = 0; k < CB_DEPTH; k++) begin
        if (cb_q[k].v && dep(iq_q[i].i, cb_q[k].wr, cb_q[k].fp, cb_q[k].dst)) begin
          hz = 1'b1;
        end
      end
      if (i == 1) begin
        hz = hz || dep(iq_q[1].i, iq_q[0].i.wr, iq_q[0].i.fp, iq_q[0].i.dst)
                || iq_q[0].i.ser || iq_q[1].i.unit == iq_q[0].i.unit;
      end
      if (iq_q[i].i.xfer == XF_FROM && (to_ret_fl || to_cnt_fl)) begin
        hz = 1'b1;
      end
      if (iq_q[i].i.ser && cb_n_q != 3'h0) begin
        hz = 1'b1;
      end
      if (!stop && iq_n_q > 3'(i) && iq_q[i].i.unit != U_BR && free > 3'(i)
          && rs_ready[iq_q[i].i.unit[1:0]] && !hz
          && !(iq_q[i].i.unit == U_INT && int_busy)) begin
        dgo[i] = 1'b1;
      end else begin
        stop = 1'b1;
      end
      if (dgo[i]) begin
        to_ret_fl = to_ret_fl || iq_q[i].i.xfer == XF_TO_RET;
        to_cnt_fl = to_cnt_fl || iq_q[i].i.xfer == XF_TO_CNT;
      end
    end
    nd = {1'b0, dgo[0]} + {1'b0, dgo[1]};
  end

  // branch folding at the entry behind the dispatched ones
  always_comb begin
    be = iq_q[nd];
    cw = 1'b0;
    for (int k = 0; k < CB_DEPTH; k++) begin
      if (cb_q[k].v && chit(cb_q[k].wcond, cb_q[k].dst, be.i.cbit)) begin
        cw = 1'b1;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (dgo[i] && chit(iq_q[i].i.wcond, iq_q[i].i.dst, be.i.cbit)) begin
        cw = 1'b1;
      end
    end
    bvalid   = iq_n_q > {1'b0, nd} && be.i.unit == U_BR && !flush;
    known    = !be.i.cond || !cw;
    tgt_busy = ((be.i.bk == BK_RET || be.i.link) && to_ret_fl)
            || (be.i.bk == BK_CNT && to_cnt_fl);
    fold_go  = bvalid && bs_q == BS_IDLE && !tgt_busy;
    fold_spec = fold_go && !known;
    taken    = known ? (!be.i.cond || cond_reg_q[be.i.cbit] == be.i.sense)
                     : be.i.pred;
    case (be.i.bk)
      BK_RET:  br_tgt = return_q;
      BK_CNT:  br_tgt = count_q;
      default: br_tgt = be.pc + {{14{be.i.disp[15]}}, be.i.disp, 2'b00};
    endcase
    redirect    = flush || (fold_go && taken);
    redirect_pc = flush ? pb_alt_q : br_tgt;
  end

  // queue next state
  always_comb begin
    logic [2:0] nrem;
    logic [2:0] nleft;
    nrem  = {1'b0, nd} + {2'b00, fold_go};
    acc   = (fetch_ack && !redirect) ? ((fetch_cnt < fetch_want_q) ? fetch_cnt
                                                                  : fetch_want_q) : 2'b00;
    nleft = redirect ? 3'h0 : iq_n_q - nrem;
    for (int j = 0; j < IQ_DEPTH; j++) begin
      iq_d[j] = (j + 32'(nrem) < IQ_DEPTH) ? iq_q[j + 32'(nrem)] : '0;
    end
    for (int a = 0; a < 2; a++) begin
      if (2'(a) < acc && 32'(nleft) + a < IQ_DEPTH) begin
        iq_d[32'(nleft) + a] = {fetch_insn[a], fetch_addr_q + (a != 0 ? INSN_BYTES : 32'h0)};
      end
    end
    iq_n_d = nleft + {1'b0, acc};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      iq_n_q <= 3'h0;
      for (int j = 0; j < IQ_DEPTH; j++) begin
        iq_q[j] <= '0;
      end
    end else begin
      iq_n_q <= iq_n_d;
      for (int j = 0; j < IQ_DEPTH; j++) begin
        iq_q[j] <= iq_d[j];
      end
    end
  end

  // fetch request follows free queue space
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fetch_addr_q <= RESET_VECTOR;
      fetch_want_q <= FETCH_MAX;
    end else begin
      fetch_addr_q <= redirect ? redirect_pc : fetch_addr_q + {28'h000_0000, acc, 2'b00};
      fetch_want_q <= (IQ_CNT_MAX - iq_n_d >= 3'h2) ? FETCH_MAX
                                                  : 2'(IQ_CNT_MAX - iq_n_d);
    end
  end

  // branch state and pending prediction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bs_q       <= BS_IDLE;
      pb_cbit_q  <= 5'h00;
      pb_sense_q <= 1'b0;
      pb_pred_q  <= 1'b0;
      pb_link_q  <= 1'b0;
      pb_alt_q   <= CLEAR_WORD;
      pb_ret_q   <= CLEAR_WORD;
    end else begin
      case (bs_q)
        BS_IDLE: begin
          if (fold_spec) begin
            bs_q       <= BS_SPEC;
            pb_cbit_q  <= be.i.cbit;
            pb_sense_q <= be.i.sense;
            pb_pred_q  <= be.i.pred;
            pb_link_q  <= be.i.link;
            pb_alt_q   <= be.i.pred ? be.pc + INSN_BYTES : br_tgt;
            pb_ret_q   <= return_q;
          end
        end
        BS_SPEC: begin
          if (res_go) begin
            bs_q <= BS_IDLE;
          end
        end
        default: bs_q <= BS_IDLE;
      endcase
    end
  end

  // retirement from the head
  always_comb begin
    ridx[0] = cb_head_q;
    ridx[1] = wrap5({1'b0, cb_head_q} + 4'h1);
    rgo[0]  = cb_n_q != 3'h0 && cb_q[ridx[0]].v && cb_q[ridx[0]].done
              && !cb_q[ridx[0]].spec;
    rgo[1]  = rgo[0] && cb_n_q > 3'h1 && cb_q[ridx[1]].v && cb_q[ridx[1]].done
              && !cb_q[ridx[1]].spec;
    nret    = {1'b0, rgo[0]} + {1'b0, rgo[1]};
    for (int r = 0; r < 2; r++) begin
      g_we[r] = rgo[r] && cb_q[ridx[r]].wr && !cb_q[ridx[r]].fp;
      f_we[r] = rgo[r] && cb_q[ridx[r]].wr && cb_q[ridx[r]].fp;
      w_a[r]  = cb_q[ridx[r]].dst;
      w_d[r]  = cb_q[ridx[r]].data;
    end
    g_ra = {iq_q[1].i.sb, iq_q[1].i.sa, iq_q[0].i.sb, iq_q[0].i.sa};
  end

  // completion buffer: allocation, results, retire, flush
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cb_head_q <= 3'h0;
      cb_n_q    <= 3'h0;
      for (int k = 0; k < CB_DEPTH; k++) begin
        cb_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < CB_DEPTH; k++) begin
        for (int p = 0; p < 2; p++) begin
          if (done_in[p].v && done_in[p].tag == 3'(k) && cb_q[k].v) begin
            cb_q[k].done <= 1'b1;
            cb_q[k].data <= done_in[p].data;
          end
          if (rgo[p] && ridx[p] == 3'(k)) begin
            cb_q[k].v <= 1'b0;
          end
        end
        if (res_ok) begin
          cb_q[k].spec <= 1'b0;
        end
        if (flush && cb_q[k].spec) begin
          cb_q[k].v <= 1'b0;
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (dgo[i]) begin
          cb_q[wrap5({1'b0, cb_head_q} + {1'b0, cb_n_q} + 4'(i))] <= '{
            v: 1'b1, done: iq_q[i].i.xfer == XF_FROM,
            spec: bs_q == BS_SPEC && !res_ok, wr: iq_q[i].i.wr, fp: iq_q[i].i.fp,
            wcond: iq_q[i].i.wcond, xfer: iq_q[i].i.xfer, dst: iq_q[i].i.dst,
            data: iq_q[i].i.sa[0] ? count_q : return_q};
        end
      end
      cb_head_q <= wrap5({1'b0, cb_head_q} + {2'b00, nret});
      cb_n_q    <= cb_n_q + {1'b0, nd} - {1'b0, nret} - (flush ? nspec : 3'h0);
    end
  end

  // architected branch-side registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cond_reg_q <= CLEAR_WORD;
      return_q   <= CLEAR_WORD;
      count_q    <= CLEAR_WORD;
    end else begin
      if (fold_go && be.i.link) begin
        return_q <= be.pc + INSN_BYTES;
      end else if (flush && pb_link_q) begin
        return_q <= pb_ret_q;
      end
      for (int r = 0; r < 2; r++) begin
        if (rgo[r] && cb_q[ridx[r]].wcond) begin
          cond_reg_q[{cb_q[ridx[r]].dst[2:0], 2'b00} +: 4] <= cb_q[ridx[r]].data[3:0];
        end
        if (rgo[r] && cb_q[ridx[r]].xfer == XF_TO_RET) begin
          return_q <= cb_q[ridx[r]].data;
        end
        if (rgo[r] && cb_q[ridx[r]].xfer == XF_TO_CNT) begin
          count_q <= cb_q[ridx[r]].data;
        end
      end
    end
  end

  // register files, read at dispatch
  ssfd_regfile u_gen (
    .clock   (clock),
    .reset_n (reset_n),
    .we      (g_we),
    .waddr   (w_a),
    .wdata   (w_d),
    .raddr   (g_ra),
    .rdata   (g_rd)
  );

  ssfd_regfile u_flt (
    .clock   (clock),
    .reset_n (reset_n),
    .we      (f_we),
    .waddr   (w_a),
    .wdata   (w_d),
    .raddr   (g_ra),
    .rdata   (f_rd)
  );

  // issue to reservation stations; float operands of any class pass untrapped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      disp_valid_q <= 2'b00;
      disp_q       <= '0;
      flush_q      <= 1'b0;
      retire_cnt_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        disp_valid_q[i] <= dgo[i] && iq_q[i].i.xfer != XF_FROM;
        disp_q[i].i     <= iq_q[i].i;
        disp_q[i].tag   <= wrap5({1'b0, cb_head_q} + {1'b0, cb_n_q} + 4'(i));
        disp_q[i].spec  <= bs_q == BS_SPEC && !res_ok;
        disp_q[i].opa   <= iq_q[i].i.fp ? f_rd[2 * i] : g_rd[2 * i];
        disp_q[i].opb   <= iq_q[i].i.fp ? f_rd[2 * i + 1] : g_rd[2 * i + 1];
      end
      flush_q      <= flush;
      retire_cnt_q <= nret;
    end
  end

  property p_iq_bound;
    @(posedge clock) disable iff (!reset_n) iq_n_q <= IQ_CNT_MAX;
  endproperty
  a_iq_bound: assert property (p_iq_bound) else $error("queue over six");

  property p_want;
    @(posedge clock) disable iff (!reset_n)
      {1'b0, iq_n_q} + {2'b00, fetch_want_q} <= 4'h6
      && (iq_n_q > 3'h4 || fetch_want_q == 2'h2);
  endproperty
  a_want: assert property (p_want) else $error("fetch request not matched to space");

  property p_disp_order;
    @(posedge clock) disable iff (!reset_n)
      disp_valid_q[1] |-> disp_valid_q[0] || disp_q[0].i.xfer == XF_FROM;
  endproperty
  a_disp_order: assert property (p_disp_order) else $error("second slot without first");

  property p_ser;
    @(posedge clock) disable iff (!reset_n)
      (disp_valid_q[0] && disp_q[0].i.ser) |-> $past(cb_n_q) == 3'h0 && !disp_valid_q[1];
  endproperty
  a_ser: assert property (p_ser) else $error("serialized dispatch with work in flight");

  property p_no_fold_spec;
    @(posedge clock) disable iff (!reset_n) bs_q == BS_SPEC |-> !fold_go;
  endproperty
  a_no_fold_spec: assert property (p_no_fold_spec) else $error("branch past prediction");

  property p_spec_retire;
    @(posedge clock) disable iff (!reset_n) rgo[0] |-> !cb_q[cb_head_q].spec;
  endproperty
  a_spec_retire: assert property (p_spec_retire) else $error("spec entry retired");

  property p_flush;
    @(posedge clock) disable iff (!reset_n)
      flush |=> flush_q && iq_n_q == 3'h0 && bs_q == BS_IDLE && fetch_addr_q == $past(pb_alt_q);
  endproperty
  a_flush: assert property (p_flush) else $error("mispredict not recovered");

  property p_link;
    @(posedge clock) disable iff (!reset_n)
      (fold_go && be.i.link) |=> return_q == $past(be.pc) + INSN_BYTES;
  endproperty
  a_link: assert property (p_link) else $error("return address not written");

  property p_int_one;
    @(posedge clock) disable iff (!reset_n)
      disp_valid_q == 2'b11 |-> !(disp_q[0].i.unit == U_INT && disp_q[1].i.unit == U_INT);
  endproperty
  a_int_one: assert property (p_int_one) else $error("two integer issues at once");

  property p_cb_bound;
    @(posedge clock) disable iff (!reset_n)
      cb_n_q <= CB_CNT_MAX && (cb_n_q != CB_CNT_MAX || !dgo[0]);
  endproperty
  a_cb_bound: assert property (p_cb_bound) else $error("completion buffer overrun");

endmodule

// ---- bench/ssfd_partner.sv ----
// cache and execution-unit model facing the front end
// assumes one clock; the bench supplies the program image and slow mode
`timescale 1ns/1ns
module ssfd_partner
  import ssfd_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              slow,
  input  wire ssfd_insn_s [31:0] prog,
  input  wire logic [31:0]       fetch_addr_q,
  input  wire logic [1:0]        fetch_want_q,
  output logic                   fetch_ack,
  output logic [1:0]             fetch_cnt,
  output ssfd_insn_s [1:0]       fetch_insn,
  input  wire logic [1:0]        disp_valid_q,
  input  wire ssfd_disp_s [1:0]  disp_q,
  input  wire logic              flush_q,
  output ssfd_done_s [1:0]       done_in
);
  logic       tog_q;
  logic [4:0] idx;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) tog_q <= 1'b0;
    else tog_q <= ~tog_q;
  end

  // answer in the request cycle; slow mode only every other cycle
  assign fetch_ack = reset_n & (~slow | tog_q);
  assign fetch_cnt = fetch_want_q;
  assign idx = fetch_addr_q[6:2];
  // idle lines carry the inverted word
  assign fetch_insn[0] = fetch_ack ? prog[idx] : ~prog[idx];
  assign fetch_insn[1] = fetch_ack ? prog[idx + 5'h1] : ~prog[idx + 5'h1];

  // result one cycle after issue, value is the word's displacement
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_in <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        done_in[p].v    <= disp_valid_q[p] & ~flush_q;
        done_in[p].tag  <= disp_q[p].tag;
        done_in[p].data <= disp_valid_q[p] ? {16'h0000, disp_q[p].i.disp} : ~done_in[p].data;
      end
    end
  end
endmodule

// ---- bench/superscalar_fetch_dispatch_branch_test.sv ----
// self-checking bench of the fetch, dispatch and branch front end
// assumes ssfd_partner as cache and units; bench drives stalls and reset
`timescale 1ns/1ns
module superscalar_fetch_dispatch_branch_test
  import ssfd_pkg::*;
;
  typedef struct packed {
    ssfd_insn_s  w0;
    ssfd_insn_s  w1;
    logic [31:0] ret;
    logic [31:0] cnt;
    logic [31:0] cnd;
    logic [1:0]  nfl;
    logic [3:0]  nret;
  } ssfd_row_s;

  logic              clock = 1'b0;
  logic              reset_n = 1'b0;
  logic              slow = 1'b0;
  logic [3:0]        rs_ready = 4'hf;
  logic              int_busy = 1'b0;
  ssfd_insn_s [31:0] prog;
  logic [31:0]       fetch_addr_q;
  logic [1:0]        fetch_want_q;
  logic              fetch_ack;
  logic [1:0]        fetch_cnt;
  ssfd_insn_s [1:0]  fetch_insn;
  logic [1:0]        disp_valid_q;
  ssfd_disp_s [1:0]  disp_q;
  ssfd_done_s [1:0]  done_in;
  logic              flush_q;
  logic [1:0]        retire_cnt_q;
  logic [31:0]       cond_reg_q;
  logic [31:0]       return_q;
  logic [31:0]       count_q;
  logic [7:0]        retired;
  logic [7:0]        flushes;
  logic [7:0]        issued;
  logic              dual;
  int                mismatches = 0;
  int                compares = 0;
  int                cycles = 0;

  always #25 clock = ~clock;

  ssfd_core DUT (.*);
  ssfd_partner far_side (.*);

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (!reset_n) begin
      retired <= '0;
      flushes <= '0;
      issued  <= '0;
      dual    <= 1'b0;
    end else begin
      retired <= retired + 8'(retire_cnt_q);
      flushes <= flushes + 8'(flush_q);
      issued  <= issued + 8'(disp_valid_q[0]) + 8'(disp_valid_q[1]);
      if (disp_valid_q === 2'b11) dual <= 1'b1;
    end
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic ssfd_insn_s mk(logic [2:0] u, logic [1:0] bk, logic [4:0] f,
                                    logic [1:0] xf, logic [15:0] d);
    mk = '0;
    mk.unit = u;
    mk.bk = bk;
    {mk.link, mk.cond, mk.pred, mk.sense, mk.wcond} = f;
    mk.xfer = xf;
    mk.disp = d;
  endfunction

  // reset held four cycles, idle outputs checked before release
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (4) @(negedge clock);
    chk(fetch_addr_q, RESET_VECTOR, "reset addr");
    chk(32'(fetch_want_q), 32'(FETCH_MAX), "reset want");
    chk(32'({disp_valid_q, flush_q, retire_cnt_q}), 32'h0, "reset idle");
    reset_n = 1'b1;
  endtask

  initial begin
    ssfd_insn_s halt;
    ssfd_insn_s wc;
    ssfd_row_s  rows [6];
    int         n;
    halt = mk(U_BR, BK_REL, 5'h00, XF_NONE, 16'h0000);
    wc = mk(U_SYS, BK_REL, 5'h01, XF_NONE, 16'h0001);
    // word0, word1, return, count, condition, flushes, retired
    rows[0] = '{mk(U_BR, BK_REL, 5'h10, XF_NONE, 16'h0010), halt,
                32'h0000_0104, 32'h0, 32'h0, 2'h0, 4'h0};
    rows[1] = '{mk(U_SYS, BK_REL, 5'h00, XF_TO_RET, 16'h0140), mk(U_BR, BK_RET, 5'h00, XF_NONE,
                16'h0000), 32'h0000_0140, 32'h0, 32'h0, 2'h0, 4'h1};
    rows[2] = '{mk(U_SYS, BK_REL, 5'h00, XF_TO_CNT, 16'h0140), mk(U_BR, BK_CNT, 5'h00, XF_NONE,
                16'h0000), 32'h0, 32'h0000_0140, 32'h0, 2'h0, 4'h1};
    rows[3] = '{wc, mk(U_BR, BK_REL, 5'h0a, XF_NONE, 16'h000f),
                32'h0, 32'h0, 32'h0000_0001, 2'h1, 4'h1};
    rows[4] = '{wc, mk(U_BR, BK_REL, 5'h0e, XF_NONE, 16'h000f),
                32'h0, 32'h0, 32'h0000_0001, 2'h0, 4'h1};
    rows[5] = '{mk(U_FLT, BK_REL, 5'h00, XF_NONE, 16'h0000), mk(U_BR, BK_REL, 5'h08, XF_NONE,
                16'h000f), 32'h0, 32'h0, 32'h0, 2'h0, 4'h1};
    for (int r = 0; r < 6; r++) begin
      prog = {32{halt}};
      prog[0] = rows[r].w0;
      prog[1] = rows[r].w1;
      do_reset();
      n = 0;
      while (fetch_addr_q !== 32'h0000_0140 && n < 80) begin
        @(negedge clock);
        n++;
      end
      repeat (10) @(negedge clock);
      chk(32'(n < 80), 32'h1, "target reached");
      chk(return_q, rows[r].ret, "return");
      chk(count_q, rows[r].cnt, "count");
      chk(cond_reg_q, rows[r].cnd, "condition");
      chk(32'(flushes), 32'(rows[r].nfl), "flushes");
      chk(32'(retired), 32'(rows[r].nret), "retired");
      $display("row %0d done", r);
    end
    // stations full: queue fills to six and fetch stops asking
    prog = {32{mk(U_INT, BK_REL, 5'h00, XF_NONE, 16'h0000)}};
    rs_ready = 4'h0;
    do_reset();
    repeat (12) @(negedge clock);
    chk(32'(fetch_want_q), 32'h0, "queue full want");
    chk(fetch_addr_q, 32'h0000_0118, "queue full addr");
    chk(32'(issued), 32'h0, "no station");
    rs_ready = 4'hf;
    $display("queue fill test done");
    // integer unit busy holds the pair, then both go together
    prog = {32{halt}};
    prog[0] = mk(U_INT, BK_REL, 5'h00, XF_NONE, 16'h0000);
    prog[1] = mk(U_FLT, BK_REL, 5'h00, XF_NONE, 16'h0000);
    slow = 1'b1;
    int_busy = 1'b1;
    do_reset();
    repeat (12) @(negedge clock);
    chk(32'(issued), 32'h0, "busy hold");
    int_busy = 1'b0;
    repeat (12) @(negedge clock);
    chk(32'(dual), 32'h1, "dual issue");
    chk(32'(retired), 32'h2, "retire pair");
    $display("busy test done");
    report_and_stop();
  end
endmodule
